// [verilog/seq_pkg.sv]
// Package: opcodes, field positions, phase numbers and carried types of the control/IO sequencer.
// Assumes a single 10 MHz processor clock; no timing figure needs conversion to cycles.
package seq_pkg;
  localparam logic [7:0] OP_HALT = 8'hF0;
  localparam logic [7:0] OP_ADV_LEVEL = 8'hF1;
  localparam logic [7:0] OP_JUMP = 8'hF2;
  localparam logic [7:0] OP_START_IO = 8'hF3;
  localparam logic [7:0] OP_BRANCH_MASK = 8'hCF;
  localparam logic [7:0] OP_BRANCH_CODE = 8'hC0;
  localparam logic [7:0] OP_TEST_IO_MASK = 8'hCF;
  localparam logic [7:0] OP_TEST_IO_CODE = 8'hC1;
  localparam logic [7:0] OP_LOAD_ADDR_MASK = 8'hCF;
  localparam logic [7:0] OP_LOAD_ADDR_CODE = 8'hC2;
  // Q byte numbering is 0 = MSB, so Q bit 0 is vector bit 7
  localparam int Q_SENSE_BIT = 7;
  localparam int Q_XR_HI = 1;
  localparam int Q_XR_LO = 0;
  localparam int OP_XR_HI = 5;
  localparam int OP_XR_LO = 4;
  localparam logic [2:0] COND_FIELD_ZERO = 3'h0;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  localparam logic [15:0] ADDR_ONE = 16'h0001;
  localparam logic [3:0] PH_0 = 4'h0;
  localparam logic [3:0] PH_4 = 4'h4;
  localparam logic [3:0] PH_5 = 4'h5;
  localparam logic [3:0] PH_8 = 4'h8;
  localparam logic [3:0] PH_9 = 4'h9;
  localparam logic [3:0] PH_SAMPLE = 4'h3;
  localparam int NUM_LEVELS = 5;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] q_byte;
    logic [7:0] ctrl_byte;
    logic [15:0] target;
    logic is_four_byte;
  } instr_t;

  typedef struct packed {
    logic start;
    logic program_load;
    logic alter_address;
    logic display_storage;
    logic storage_run;
    logic addr_increment;
    logic [15:0] switches;
  } console_t;

  typedef enum logic [6:0] {
    ST_RESET = 7'h01,
    ST_IDLE = 7'h02,
    ST_EXEC = 7'h04,
    ST_HALT = 7'h08,
    ST_LOAD = 7'h10,
    ST_ALTER = 7'h20,
    ST_DISPLAY = 7'h40
  } seq_state_t;
endpackage

// [verilog/control_io_instruction_sequencer.sv]
// Control/IO instruction sequencer: branch, jump, start I/O, test I/O, advance level,
// halt, load address, reset/program load, console alter and display cycles, interrupt poll.
// Assumes: instr_valid_in is a one-cycle pulse from the fetch logic on the same clock;
// condition lines and console switches come from outside and are synchronised here.
// Functional notes
// - Conditional branch tests condition register and loads target into recall register.
// - Q bit 0 picks branch on condition true or on false.
// - Satisfied branch swaps instruction address and recall registers.
// - Jump F2 adds control byte to instruction address when condition holds.
// - Q bit 0 picks jump on condition true or on false.
// - Start I/O F3 sends device address, function and control byte to attachments.
// - Busy reply during start I/O repeats the same instruction until not busy.
// - Test I/O loads target into recall register and swaps when condition met.
// - Line B only on test I/O means not met; go on sequentially.
// - Line A only on test I/O means met; branch to target.
// - Both lines active raises processor check and output bus parity check.
// - Neither line active raises processor check and invalid device address.
// - Four-byte load address puts two-byte address in index register by Q bits 6-7.
// - Three-byte form adds last byte to op-selected index register, stores by Q bits.
// - Advance level F1 repeats while tested I/O condition still exists.
// - Advance level with all-zero condition field proceeds without looping.
// - Line B only means accepted; line A only means busy, rejected.
// - Halt F0 blocks next instruction until start, shows bytes three and four.
// - Program load resets instruction address and disk data; first fetch at 0000.
// - Line B at end of load clears program-load latch and enters run.
// - Display run mode recycles skipping phase 9; increment address each cycle if on.
// - Interrupt polled at op end phases 5-8; highest level wins, selects its address.
`timescale 1ns/1ps
module control_io_instruction_sequencer
  import seq_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire instr_t instr_in,
  input wire logic [5:0] cond_reg_in,
  input wire logic cond_line_a_in,
  input wire logic cond_line_b_in,
  input wire console_t console_in,
  input wire logic [NUM_LEVELS-1:0] int_request_in,
  input wire logic [NUM_LEVELS-1:0] int_enable_in,
  output logic [15:0] instruction_address_reg_out,
  output logic [15:0] address_recall_reg_out,
  output logic [15:0] storage_address_reg_out,
  output logic [7:0] disk_data_reg_out,
  output logic [15:0] index_reg1_out,
  output logic [15:0] index_reg2_out,
  output logic [7:0] output_data_bus_out,
  output logic [7:0] io_ctrl_byte_out,
  output logic io_strobe_out,
  output logic [15:0] console_display_out,
  output logic [3:0] phase_out,
  output logic instr_done_out,
  output logic processor_check_out,
  output logic bus_parity_check_out,
  output logic invalid_device_out,
  output logic parity_check_enable_out,
  output logic program_load_sequence_out,
  output logic [2:0] active_level_out,
  output logic int_granted_out
);

  typedef struct packed {
    seq_state_t st;
    logic [3:0] phase;
    instr_t ir;
    logic [15:0] instruction_address_reg;
    logic [15:0] address_recall_reg;
    logic [15:0] storage_address_reg;
    logic [7:0] ddr;
    logic [15:0] xr1;
    logic [15:0] xr2;
    logic [7:0] output_data_bus;
    logic [7:0] ctl;
    logic strobe;
    logic [15:0] disp;
    logic done;
    logic pchk;
    logic bchk;
    logic inv;
    logic par_en;
    logic load_latch;
    logic sampled;
    logic resp_a;
    logic resp_b;
    logic [2:0] level;
    logic [2:0] prev_level;
    logic granted;
    logic [NUM_LEVELS-1:0][15:0] lvl_iar;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Two-stage synchronisers for pins; only stage two is read by logic
  logic [1:0] line_a_sync_q;
  logic [1:0] line_b_sync_q;
  // Console word passes as one struct; operator switches are static while a key is pressed
  console_t console_s1_q;
  console_t console_s2_q;
  logic line_a;
  logic line_b;
  logic start_key;
  logic load_key;
  logic run_mode;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_a_sync_q <= 2'h0;
      line_b_sync_q <= 2'h0;
      console_s1_q <= '0;
      console_s2_q <= '0;
    end else begin
      line_a_sync_q <= {line_a_sync_q[0], cond_line_a_in};
      line_b_sync_q <= {line_b_sync_q[0], cond_line_b_in};
      console_s1_q <= console_in;
      console_s2_q <= console_s1_q;
    end
  end

  assign line_a = line_a_sync_q[1];
  assign line_b = line_b_sync_q[1];
  assign start_key = console_s2_q.start;
  assign load_key = console_s2_q.program_load;
  assign run_mode = console_s2_q.storage_run;

  // Decode helpers
  logic is_command;
  logic is_branch;
  logic is_test_io;
  logic is_load_addr;
  logic cond_hit;
  logic sense_true;
  logic [15:0] sel_xr;
  logic [2:0] best_level;
  logic any_int;

  // Op bits 2-3 both set mark the command group; without this halt would decode as a branch
  assign is_command = &s_q.ir.opcode[OP_XR_HI:OP_XR_LO];
  assign is_branch = ((s_q.ir.opcode & OP_BRANCH_MASK) == OP_BRANCH_CODE) && !is_command;
  assign is_test_io = ((s_q.ir.opcode & OP_TEST_IO_MASK) == OP_TEST_IO_CODE) && !is_command;
  assign is_load_addr = ((s_q.ir.opcode & OP_LOAD_ADDR_MASK) == OP_LOAD_ADDR_CODE) && !is_command;
  assign sense_true = s_q.ir.q_byte[Q_SENSE_BIT];
  // Any selected condition bit counts; Q bit 0 clear inverts the sense
  assign cond_hit = ((|(cond_reg_in & s_q.ir.q_byte[5:0])) == sense_true);
  assign sel_xr = s_q.ir.opcode[OP_XR_LO] ? s_q.xr1 : s_q.xr2;

  // Priority: lowest index is the highest level
  always_comb begin
    best_level = 3'h0;
    any_int = 1'b0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (int_request_in[i] && int_enable_in[i]) begin
        best_level = 3'(i);
        any_int = 1'b1;
      end
    end
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    s_d.done = 1'b0;
    s_d.granted = 1'b0;
    s_d.phase = (s_q.phase == PH_9) ? PH_0 : s_q.phase + 4'h1;
    unique case (s_q.st)
      ST_RESET: begin
        s_d.instruction_address_reg = ADDR_ZERO;
        s_d.ddr = 8'h00;
        s_d.par_en = 1'b0;
        if (s_q.phase == PH_9) begin
          s_d.st = s_q.load_latch ? ST_LOAD : ST_IDLE;
          s_d.par_en = 1'b1;
          s_d.storage_address_reg = ADDR_ZERO;
        end
      end
      ST_LOAD: begin
        if (line_b) begin
          s_d.load_latch = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        s_d.phase = PH_0;
        if (load_key) begin
          s_d.load_latch = 1'b1;
          s_d.st = ST_RESET;
        end else if (console_s2_q.alter_address && start_key) begin
          s_d.st = ST_ALTER;
        end else if (console_s2_q.display_storage && start_key) begin
          s_d.st = ST_DISPLAY;
        end else if (instr_valid_in) begin
          s_d.ir = instr_in;
          s_d.sampled = 1'b0;
          s_d.st = ST_EXEC;
        end
      end
      ST_ALTER: begin
        if (s_q.phase == PH_4 && start_key) s_d.phase = PH_4;
        if (s_q.phase == PH_0) s_d.instruction_address_reg = console_s2_q.switches;
        if (s_q.phase == PH_9) begin
          s_d.storage_address_reg = s_q.instruction_address_reg;
          s_d.st = ST_IDLE;
        end
      end
      ST_DISPLAY: begin
        s_d.storage_address_reg = s_q.instruction_address_reg;
        if (run_mode && s_q.phase == PH_8) s_d.phase = PH_0;
        if (console_s2_q.addr_increment && (s_q.phase == PH_8 || s_q.phase == PH_9)) begin
          if (run_mode || s_q.phase == PH_9) s_d.instruction_address_reg = s_q.instruction_address_reg + ADDR_ONE;
        end
        if (!run_mode && s_q.phase == PH_4 && start_key) s_d.phase = PH_4;
        if (!run_mode && s_q.phase == PH_9) s_d.st = ST_IDLE;
      end
      ST_HALT: begin
        s_d.disp = {s_q.ir.ctrl_byte, s_q.ir.target[7:0]};
        s_d.phase = PH_0;
        if (start_key) s_d.st = ST_IDLE;
      end
      ST_EXEC: begin
        // One sample of the lines per instruction, held to its end
        if (s_q.phase == PH_SAMPLE && !s_q.sampled) begin
          s_d.sampled = 1'b1;
          s_d.resp_a = line_a;
          s_d.resp_b = line_b;
        end
        if (s_q.phase == PH_0 && (s_q.ir.opcode == OP_START_IO || s_q.ir.opcode == OP_ADV_LEVEL ||
            is_test_io)) begin
          s_d.output_data_bus = s_q.ir.q_byte;
          s_d.ctl = s_q.ir.ctrl_byte;
          s_d.strobe = 1'b1;
        end
        if (s_q.phase == PH_5) begin
          if (is_branch || is_test_io) s_d.address_recall_reg = s_q.ir.target;
        end
        if (s_q.phase == PH_9) begin
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
          if (is_branch && cond_hit) begin
            s_d.instruction_address_reg = s_q.ir.target;
            s_d.address_recall_reg = s_q.instruction_address_reg;
          end else if (s_q.ir.opcode == OP_JUMP && cond_hit) begin
            s_d.instruction_address_reg = s_q.instruction_address_reg + {8'h00, s_q.ir.ctrl_byte};
          end else if (is_load_addr) begin
            if (s_q.ir.is_four_byte) begin
              if (s_q.ir.q_byte[Q_XR_LO]) s_d.xr1 = s_q.ir.target;
              if (s_q.ir.q_byte[Q_XR_HI]) s_d.xr2 = s_q.ir.target;
            end else begin
              if (s_q.ir.q_byte[Q_XR_LO]) s_d.xr1 = sel_xr + {8'h00, s_q.ir.target[7:0]};
              if (s_q.ir.q_byte[Q_XR_HI]) s_d.xr2 = sel_xr + {8'h00, s_q.ir.target[7:0]};
            end
          end else if (s_q.ir.opcode == OP_HALT) begin
            s_d.st = ST_HALT;
            s_d.done = 1'b0;
          end else if (s_q.ir.opcode == OP_START_IO || s_q.ir.opcode == OP_ADV_LEVEL || is_test_io) begin
            if (s_q.resp_a && s_q.resp_b) begin
              s_d.pchk = 1'b1;
              s_d.bchk = 1'b1;
            end else if (!s_q.resp_a && !s_q.resp_b) begin
              if (!(s_q.ir.opcode == OP_ADV_LEVEL && s_q.ir.q_byte[2:0] == COND_FIELD_ZERO)) begin
                s_d.pchk = 1'b1;
                s_d.inv = 1'b1;
              end
            end else if (is_test_io && s_q.resp_a) begin
              s_d.instruction_address_reg = s_q.ir.target;
              s_d.address_recall_reg = s_q.instruction_address_reg;
            end else if (s_q.resp_a && !(s_q.ir.opcode == OP_ADV_LEVEL &&
                         s_q.ir.q_byte[2:0] == COND_FIELD_ZERO)) begin
              // Busy or condition persists: rerun same instruction
              s_d.st = ST_EXEC;
              s_d.sampled = 1'b0;
              s_d.done = 1'b0;
            end
            // Line B only: fall through to the next instruction
          end
        end
        // Interrupt poll during op-end phases 5 to 8
        if (s_q.phase >= PH_5 && s_q.phase <= PH_8 && any_int && s_q.level != best_level) begin
          s_d.granted = (s_q.phase == PH_8);
          if (s_q.phase == PH_8) begin
            s_d.level = best_level;
            s_d.prev_level = s_q.level;
          end
        end
      end
      default: s_d.st = ST_RESET;
    endcase
    // Level switch swaps in that level's saved instruction address
    // Swap falls in the closing phase, so the finished instruction's address is what gets saved
    if (s_q.granted) begin
      s_d.lvl_iar[s_q.prev_level] = s_d.instruction_address_reg;
      s_d.instruction_address_reg = s_q.lvl_iar[s_q.level];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.st <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // All outputs straight from the state register
  assign instruction_address_reg_out = s_q.instruction_address_reg;
  assign address_recall_reg_out = s_q.address_recall_reg;
  assign storage_address_reg_out = s_q.storage_address_reg;
  assign disk_data_reg_out = s_q.ddr;
  assign index_reg1_out = s_q.xr1;
  assign index_reg2_out = s_q.xr2;
  assign output_data_bus_out = s_q.output_data_bus;
  assign io_ctrl_byte_out = s_q.ctl;
  assign io_strobe_out = s_q.strobe;
  assign console_display_out = s_q.disp;
  assign phase_out = s_q.phase;
  assign instr_done_out = s_q.done;
  assign processor_check_out = s_q.pchk;
  assign bus_parity_check_out = s_q.bchk;
  assign invalid_device_out = s_q.inv;
  assign parity_check_enable_out = s_q.par_en;
  assign program_load_sequence_out = s_q.load_latch;
  assign active_level_out = s_q.level;
  assign int_granted_out = s_q.granted;

  // Assertions
  property p_load_clear;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (s_q.st == ST_LOAD && line_b) |=> !s_q.load_latch;
  endproperty
  a_load_clear: assert property (p_load_clear) else $error("load latch not cleared");

  property p_reset_zero;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (s_q.st == ST_RESET) |=> (s_q.instruction_address_reg == ADDR_ZERO && s_q.ddr == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset did not zero registers");

  property p_both_lines;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (s_q.st == ST_EXEC && s_q.phase == PH_9 && is_test_io && s_q.resp_a && s_q.resp_b)
      |=> (processor_check_out && bus_parity_check_out);
  endproperty
  a_both_lines: assert property (p_both_lines) else $error("both lines not flagged");

  property p_no_lines;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (s_q.st == ST_EXEC && s_q.phase == PH_9 && is_test_io && !s_q.resp_a && !s_q.resp_b)
      |=> (processor_check_out && invalid_device_out);
  endproperty
  a_no_lines: assert property (p_no_lines) else $error("silent device not flagged");

  property p_sio_busy;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (s_q.st == ST_EXEC && s_q.phase == PH_9 && s_q.ir.opcode == OP_START_IO && s_q.resp_a && !s_q.resp_b)
      |=> (s_q.st == ST_EXEC && s_q.phase == PH_0 && !instr_done_out);
  endproperty
  a_sio_busy: assert property (p_sio_busy) else $error("busy start not repeated");

  property p_halt_hold;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (s_q.st == ST_HALT && !start_key) |=> (s_q.st == ST_HALT);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left without start");

  property p_alter_sar;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (s_q.st == ST_ALTER && s_q.phase == PH_9) |=> (storage_address_reg_out == $past(s_q.instruction_address_reg));
  endproperty
  a_alter_sar: assert property (p_alter_sar) else $error("storage address not loaded");

  property p_sample_once;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (s_q.st == ST_EXEC && s_q.sampled && s_q.phase != PH_9) |=> $stable(s_q.resp_a);
  endproperty
  a_sample_once: assert property (p_sample_once) else $error("response resampled");

endmodule // control_io_instruction_sequencer

// [sim/io_attach_model.sv]
// I/O attachment model: answers each I/O strobe on the two condition lines.
// Assumes strobe and done are one-cycle pulses from the sequencer clock domain.
`timescale 1ns/1ps
module io_attach_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic strobe_in,
  input wire logic done_in,
  input wire logic load_in,
  input wire logic [1:0] mode_in,
  input wire logic [3:0] busy_in,
  output logic line_a_out,
  output logic line_b_out
);
  logic [3:0] tries_q;
  logic [4:0] wait_q;
  logic a_q, b_q, pl_b_q;
  logic ans_a, ans_b;

  // Answer is on the lines in the strobe cycle itself, so it is settled before the sample phase
  assign ans_a = (tries_q < busy_in) || (mode_in == 2'd0) || (mode_in == 2'd2);
  assign ans_b = (tries_q >= busy_in) && ((mode_in == 2'd1) || (mode_in == 2'd2));

  // Mode 0 condition met, 1 not met or accepted, 2 both lines, 3 no answer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tries_q <= 4'h0;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else if (done_in) begin
      tries_q <= 4'h0; // Lines released to inactive between instructions
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else if (strobe_in) begin
      tries_q <= tries_q + 4'h1;
      a_q <= ans_a;
      b_q <= ans_b;
    end
  end

  // Load transfer ends after a fixed delay; slow on purpose to test the wait
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_q <= 5'h00;
      pl_b_q <= 1'b0;
    end else if (!load_in) begin
      wait_q <= 5'h00;
      pl_b_q <= 1'b0;
    end else if (wait_q == 5'h14) begin
      pl_b_q <= 1'b1;
    end else begin
      wait_q <= wait_q + 5'h01;
    end
  end

  assign line_a_out = strobe_in ? ans_a : a_q;
  assign line_b_out = (strobe_in ? ans_b : b_q) | pl_b_q;
endmodule // io_attach_model

// [sim/control_io_instruction_sequencer_tb.sv]
// Testbench: issues instructions, console keys and interrupt requests to the sequencer.
// Assumes the attachment model answers on the condition lines.
`timescale 1ns/1ps
module control_io_instruction_sequencer_tb;
  import seq_pkg::*;
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
  logic clk_sys_in, rst_n_in, instr_valid_in, cond_line_a_in, cond_line_b_in;
  instr_t instr_in;
  logic [5:0] cond_reg_in;
  console_t console_in;
  logic [NUM_LEVELS-1:0] int_request_in, int_enable_in;
  logic [15:0] instruction_address_reg_out, address_recall_reg_out, storage_address_reg_out;
  logic [15:0] index_reg1_out, index_reg2_out, console_display_out;
  logic [7:0] disk_data_reg_out, output_data_bus_out, io_ctrl_byte_out;
  logic [3:0] phase_out;
  logic [2:0] active_level_out;
  logic io_strobe_out, instr_done_out, processor_check_out, bus_parity_check_out, invalid_device_out;
  logic parity_check_enable_out, program_load_sequence_out, int_granted_out;
  logic [1:0] mode;
  logic [3:0] busy;
  int fails, total_checks, strobes, grants, cyc, n;

  control_io_instruction_sequencer control_io_instruction_sequencer_inst (.clk_sys_in, .rst_n_in,
    .instr_valid_in, .instr_in, .cond_reg_in, .cond_line_a_in, .cond_line_b_in, .console_in,
    .int_request_in, .int_enable_in, .instruction_address_reg_out, .address_recall_reg_out,
    .storage_address_reg_out, .disk_data_reg_out, .index_reg1_out, .index_reg2_out, .output_data_bus_out,
    .io_ctrl_byte_out, .io_strobe_out, .console_display_out, .phase_out, .instr_done_out,
    .processor_check_out, .bus_parity_check_out, .invalid_device_out, .parity_check_enable_out,
    .program_load_sequence_out, .active_level_out, .int_granted_out);

  io_attach_model io_attach_model_inst (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .strobe_in(io_strobe_out),
    .done_in(instr_done_out), .load_in(program_load_sequence_out), .mode_in(mode), .busy_in(busy),
    .line_a_out(cond_line_a_in), .line_b_out(cond_line_b_in));

  // Clock: 100 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic conclude();
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One-cycle valid pulse; the gap lets the sequencer settle back to idle
  task automatic send(input logic [7:0] op, q, c, input logic [15:0] t, input logic fb);
    repeat (2) @(posedge clk_sys_in);
    instr_valid_in <= 1'b1;
    instr_in <= '{op, q, c, t, fb};
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b0;
  endtask

  // Sampled on the falling edge so registered outputs are settled
  task automatic wait_done(input int lim);
    cyc = 0;
    strobes = 0;
    grants = 0;
    do begin
      @(negedge clk_sys_in);
      cyc++;
      if (io_strobe_out === 1'b1) strobes++;
      if (int_granted_out === 1'b1) grants++;
    end while (instr_done_out !== 1'b1 && cyc < lim);
    `CHK("done", 1'b1, instr_done_out)
  endtask

  task automatic run(input logic [7:0] op, q, c, input logic [15:0] t, input logic fb, input int lim);
    send(op, q, c, t, fb);
    wait_done(lim);
  endtask

  task automatic do_reset();
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
  endtask

  // Watchdog: the sequence needs under 2000 cycles, so 10000 means a hang
  initial begin
    #1000000;
    fails++;
    conclude();
  end

  initial begin
    rst_n_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_in = '0;
    cond_reg_in = 6'h01;
    console_in = '0;
    int_request_in = '0;
    int_enable_in = '0;
    mode = 2'd1;
    busy = 4'h0;
    fails = 0;
    total_checks = 0;
    do_reset();
    `CHK("iar_rst", 16'h0000, instruction_address_reg_out)
    `CHK("disk_rst", 8'h00, disk_data_reg_out)
    `CHK("sar_rst", 16'h0000, storage_address_reg_out)
    `CHK("par_en", 1'b1, parity_check_enable_out)
    run(8'hC0, 8'h81, 8'h00, 16'h1234, 1'b1, 40);
    `CHK("br_iar", 16'h1234, instruction_address_reg_out)
    `CHK("br_arr", 16'h0000, address_recall_reg_out)
    run(8'hC0, 8'h01, 8'h00, 16'h5678, 1'b1, 40);
    `CHK("nbr_iar", 16'h1234, instruction_address_reg_out)
    `CHK("nbr_arr", 16'h5678, address_recall_reg_out)
    // Sense false with condition false takes the jump
    run(8'hF2, 8'h02, 8'h10, 16'h0000, 1'b0, 40);
    `CHK("jmp_iar", 16'h1244, instruction_address_reg_out)
    run(8'hF2, 8'h82, 8'h10, 16'h0000, 1'b0, 40);
    `CHK("njmp_iar", 16'h1244, instruction_address_reg_out)
    run(8'hC2, 8'h01, 8'h00, 16'hABCD, 1'b1, 40);
    `CHK("xr1", 16'hABCD, index_reg1_out)
    run(8'hD2, 8'h02, 8'h00, 16'h0022, 1'b0, 40);
    `CHK("xr2", 16'hABEF, index_reg2_out)
    busy = 4'h2;
    run(8'hF3, 8'h5A, 8'h3C, 16'h0000, 1'b0, 100);
    `CHK("sio_tries", 3, strobes)
    `CHK("sio_dbo", 8'h5A, output_data_bus_out)
    `CHK("sio_ctrl", 8'h3C, io_ctrl_byte_out)
    // Busy attachment would hold a looping advance, so a quick finish proves the skip
    busy = 4'h1;
    run(8'hF1, 8'h58, 8'h00, 16'h0000, 1'b0, 100);
    `CHK("apl_skip", 1'b1, cyc < 20)
    busy = 4'h2;
    run(8'hF1, 8'h59, 8'h00, 16'h0000, 1'b0, 100);
    `CHK("apl_tries", 3, strobes)
    busy = 4'h0;
    mode = 2'd0;
    run(8'hC1, 8'h01, 8'h00, 16'h3F00, 1'b1, 40);
    `CHK("tio_iar", 16'h3F00, instruction_address_reg_out)
    `CHK("tio_arr", 16'h1244, address_recall_reg_out)
    mode = 2'd1;
    run(8'hC1, 8'h01, 8'h00, 16'h4100, 1'b1, 40);
    `CHK("ntio_iar", 16'h3F00, instruction_address_reg_out)
    `CHK("ntio_arr", 16'h4100, address_recall_reg_out)
    send(8'hF0, 8'h00, 8'hA5, 16'h00C3, 1'b0);
    n = 0;
    repeat (30) begin
      @(negedge clk_sys_in);
      if (instr_done_out === 1'b1) n++;
    end
    `CHK("halt_hold", 0, n)
    `CHK("halt_disp", 16'hA5C3, console_display_out)
    @(posedge clk_sys_in);
    console_in.start <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    console_in.start <= 1'b0;
    // Only a released halt lets the next instruction finish
    run(8'hC0, 8'h01, 8'h00, 16'h1244, 1'b1, 40);
    int_enable_in <= 5'h1F;
    int_request_in <= 5'h14;
    run(8'hC0, 8'h01, 8'h00, 16'h0100, 1'b1, 40);
    `CHK("int_grant", 1, grants)
    `CHK("int_level", 3'd2, active_level_out)
    `CHK("int_iar", 16'h0000, instruction_address_reg_out)
    int_request_in <= 5'h00;
    mode = 2'd2;
    run(8'hC1, 8'h01, 8'h00, 16'h0200, 1'b1, 40);
    `CHK("both_pchk", 1'b1, processor_check_out)
    `CHK("both_par", 1'b1, bus_parity_check_out)
    do_reset();
    mode = 2'd3;
    run(8'hC1, 8'h01, 8'h00, 16'h0200, 1'b1, 40);
    `CHK("none_pchk", 1'b1, processor_check_out)
    `CHK("none_dev", 1'b1, invalid_device_out)
    // Alter cycle: start held past phase 4, then released
    @(posedge clk_sys_in);
    console_in.switches <= 16'h2468;
    console_in.alter_address <= 1'b1;
    console_in.start <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
    console_in.start <= 1'b0;
    repeat (14) @(posedge clk_sys_in);
    console_in.alter_address <= 1'b0;
    @(negedge clk_sys_in);
    `CHK("alt_iar", 16'h2468, instruction_address_reg_out)
    `CHK("alt_sar", 16'h2468, storage_address_reg_out)
    // Display step with address increment on bumps the address once
    @(posedge clk_sys_in);
    console_in.display_storage <= 1'b1;
    console_in.addr_increment <= 1'b1;
    console_in.start <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    console_in.start <= 1'b0;
    repeat (16) @(posedge clk_sys_in);
    console_in.display_storage <= 1'b0;
    @(negedge clk_sys_in);
    `CHK("disp_iar", 16'h2469, instruction_address_reg_out)
    mode = 2'd1;
    @(posedge clk_sys_in);
    console_in.program_load <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    console_in.program_load <= 1'b0;
    n = 0;
    while (program_load_sequence_out !== 1'b1 && n < 50) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK("pl_on", 1'b1, program_load_sequence_out)
    n = 0;
    while (program_load_sequence_out !== 1'b0 && n < 100) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK("pl_off", 1'b0, program_load_sequence_out)
    `CHK("pl_iar", 16'h0000, instruction_address_reg_out)
    `CHK("pl_disk", 8'h00, disk_data_reg_out)
    conclude();
  end
endmodule // control_io_instruction_sequencer_tb
